// File: inc/status_flags_defines.svh
// offsets, bit positions, reset values and timing for the core status flag register
`ifndef STATUS_FLAGS_DEFINES_SVH
`define STATUS_FLAGS_DEFINES_SVH

`define CSF_ADDR_FLAGS 4'h0
`define CSF_ADDR_EVENT 4'h4
`define CSF_BIT_PIN_WAKE 7
`define CSF_BIT_EXPIRY 4
`define CSF_BIT_SLEEP 3
`define CSF_BIT_ZERO 2
`define CSF_BIT_NIBBLE 1
`define CSF_BIT_CARRY 0
`define CSF_UPPER_MASK 8'he0
`define CSF_ARITH_MASK 8'h07
`define CSF_FLAGS_POR 8'h18
`define CSF_CLEAR_PATTERN 8'h04
`define CSF_BUS_ANSWER_CYCLES 1

`endif

// File: inc/status_flags_pkg.sv
// types shared by the core status flag register
package status_flags_pkg;

    typedef enum logic [2:0] {
        cause_none = 3'b001,
        cause_power_up = 3'b010,
        cause_other = 3'b100
    } reset_cause_t;

    typedef struct packed {
        logic valid;
        logic write_dest;
        logic [7:0] write_data;
        logic affects_zero;
        logic affects_nibble;
        logic affects_carry;
        logic zero;
        logic nibble_carry;
        logic carry;
        logic register_clear_op;
    } exec_result_t;

    typedef struct packed {
        logic power_up;
        logic pin_wake_reset;
        logic other_reset;
        logic watchdog_timeout;
        logic watchdog_kick_op;
        logic sleep_op;
    } reset_event_t;

endpackage

// File: src/status_bus_slave.sv
// avalon-mm slave answering one cycle after the request is seen
module status_bus_slave (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic waitrequest,
    output logic [31:0] readdata,
    output logic take_write,
    output logic [3:0] take_addr,
    output logic [7:0] take_data,
    input wire logic [31:0] read_value
);
    import status_flags_pkg::*;

    // first request edge loads data and drops wait; completion edge raises it again
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0;
        end else if ((read || write) && waitrequest) begin
            waitrequest <= 1'b0;
            readdata <= read ? read_value : 32'h0;
        end else begin
            waitrequest <= 1'b1;
        end
    end

    // write lands at the edge where the master sees wait low
    always_comb begin
        take_write = write && !waitrequest;
        take_addr = address;
        take_data = writedata[7:0];
    end
endmodule

// File: src/core_status_flag_register.sv
// core status flag register with instruction write merge and reset cause flags
// Operation
// [RULE1] one readable byte holds arithmetic flags and reset cause flags
// [RULE2] any instruction may write this register like any data register
// [RULE3] flag-updating writes ignore data for zero, nibble carry, carry
// [RULE4] watchdog expiry and sleep flags ignore instruction writes
// [RULE5] register clear gives 000u u1uu: upper bits zero, zero flag set
// [RULE6] bit clear, bit set and move from accumulator leave arithmetic flags alone
// [RULE7] software leaves the two reserved bits unused
// [RULE8] reset cause flags follow pin wake, timeout, kick, sleep and power-up
//
// Decided for this implementation: register access over Avalon-MM and the register addresses.
`include "status_flags_defines.svh"
module core_status_flag_register (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire status_flags_pkg::exec_result_t exec,
    input wire status_flags_pkg::reset_event_t event_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic avs_waitrequest,
    output logic [31:0] avs_readdata,
    output logic [7:0] flags_out,
    output status_flags_pkg::reset_cause_t last_cause
);
    import status_flags_pkg::*;

    logic [7:0] core_status_flags;
    logic [7:0] next_core_status_flags;
    logic [7:0] write_mask;
    logic [2:0] event_hold;
    logic take_write;
    logic [3:0] take_addr;
    logic [7:0] take_data;
    logic [31:0] read_value;
    logic started;

    status_bus_slave bus (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .address(avs_address),
        .read(avs_read),
        .write(avs_write),
        .writedata(avs_writedata),
        .waitrequest(avs_waitrequest),
        .readdata(avs_readdata),
        .take_write(take_write),
        .take_addr(take_addr),
        .take_data(take_data),
        .read_value(read_value)
    );

    always_comb begin
        if (avs_address == `CSF_ADDR_FLAGS) begin
            read_value = {24'h0, core_status_flags}; // see [RULE1]
        end else if (avs_address == `CSF_ADDR_EVENT) begin
            read_value = {29'h0, event_hold};
        end else begin
            read_value = 32'h0;
        end
    end

    // writable positions: pin wake and arithmetic bits the instruction does not affect; reserved read zero
    always_comb begin
        write_mask = 8'h0;
        write_mask[`CSF_BIT_PIN_WAKE] = 1'b1;
        write_mask[`CSF_BIT_EXPIRY] = 1'b0; // see [RULE4]
        write_mask[`CSF_BIT_SLEEP] = 1'b0; // see [RULE4]
        write_mask[`CSF_BIT_ZERO] = !exec.affects_zero; // see [RULE3]
        write_mask[`CSF_BIT_NIBBLE] = !exec.affects_nibble; // see [RULE3]
        write_mask[`CSF_BIT_CARRY] = !exec.affects_carry; // see [RULE3]
    end

    always_comb begin
        next_core_status_flags = core_status_flags;
        if (exec.valid && exec.write_dest) begin
            if (exec.register_clear_op) begin
                // upper bits zero, zero flag set, rest kept
                next_core_status_flags = (core_status_flags & ~`CSF_UPPER_MASK
                    & ~(8'h1 << `CSF_BIT_ZERO)) | `CSF_CLEAR_PATTERN; // see [RULE5]
            end else begin
                // see [RULE2]
                next_core_status_flags = (core_status_flags & ~write_mask)
                    | (exec.write_data & write_mask);
            end
        end else if (take_write && take_addr == `CSF_ADDR_FLAGS) begin
            next_core_status_flags = (core_status_flags & ~(8'h1 << `CSF_BIT_PIN_WAKE))
                | (take_data & (8'h1 << `CSF_BIT_PIN_WAKE));
            next_core_status_flags[`CSF_BIT_ZERO] = take_data[`CSF_BIT_ZERO];
            next_core_status_flags[`CSF_BIT_NIBBLE] = take_data[`CSF_BIT_NIBBLE];
            next_core_status_flags[`CSF_BIT_CARRY] = take_data[`CSF_BIT_CARRY];
        end
        // computed flags override written data except on register clear; untouched by bit ops
        if (exec.valid && !exec.register_clear_op) begin
            if (exec.affects_zero) begin
                next_core_status_flags[`CSF_BIT_ZERO] = exec.zero; // see [RULE3] [RULE6]
            end
            if (exec.affects_nibble) begin
                next_core_status_flags[`CSF_BIT_NIBBLE] = exec.nibble_carry;
            end
            if (exec.affects_carry) begin
                next_core_status_flags[`CSF_BIT_CARRY] = exec.carry;
            end
        end
        next_core_status_flags[6:5] = 2'b00; // see [RULE7]
        // hardware events win over any write
        if (event_in.power_up) begin
            next_core_status_flags[`CSF_BIT_EXPIRY] = 1'b1; // see [RULE8]
            next_core_status_flags[`CSF_BIT_SLEEP] = 1'b1;
            next_core_status_flags[`CSF_BIT_PIN_WAKE] = 1'b0;
        end else begin
            if (event_in.pin_wake_reset) begin
                next_core_status_flags[`CSF_BIT_PIN_WAKE] = 1'b1; // see [RULE8]
            end else if (event_in.other_reset || event_in.watchdog_timeout) begin
                next_core_status_flags[`CSF_BIT_PIN_WAKE] = 1'b0;
            end
            if (event_in.watchdog_timeout) begin
                next_core_status_flags[`CSF_BIT_EXPIRY] = 1'b0; // see [RULE8]
            end else if (event_in.watchdog_kick_op || event_in.sleep_op) begin
                next_core_status_flags[`CSF_BIT_EXPIRY] = 1'b1;
            end
            if (event_in.sleep_op) begin
                next_core_status_flags[`CSF_BIT_SLEEP] = 1'b0; // see [RULE8]
            end else if (event_in.watchdog_kick_op) begin
                next_core_status_flags[`CSF_BIT_SLEEP] = 1'b1;
            end
        end
    end

    // nrst is the power-up reset of the register
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            core_status_flags <= `CSF_FLAGS_POR;
        end else begin
            core_status_flags <= next_core_status_flags;
        end
    end

    // sticky record of timeout, pin wake and sleep; bus write of ones clears, set wins
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            event_hold <= 3'h0;
        end else begin
            event_hold <= (event_hold & ~((take_write && take_addr == `CSF_ADDR_EVENT)
                ? take_data[2:0] : 3'h0))
                | {event_in.sleep_op, event_in.pin_wake_reset, event_in.watchdog_timeout};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            last_cause <= cause_power_up;
            started <= 1'b0;
        end else begin
            started <= 1'b1;
            if (event_in.power_up) begin
                last_cause <= cause_power_up;
            end else if (event_in.pin_wake_reset || event_in.other_reset
                    || event_in.watchdog_timeout) begin
                last_cause <= cause_other;
            end else if (!started) begin
                last_cause <= cause_power_up;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            flags_out <= `CSF_FLAGS_POR;
        end else begin
            flags_out <= next_core_status_flags;
        end
    end
endmodule

// File: verification/core_status_flag_register_props.sv
// concurrent checks on the core status flag register ports
module core_status_flag_register_props (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire status_flags_pkg::exec_result_t exec,
    input wire status_flags_pkg::reset_event_t event_in,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic avs_waitrequest,
    input wire logic [31:0] avs_readdata,
    input wire logic [7:0] flags_out,
    input wire status_flags_pkg::reset_cause_t last_cause
);
    import status_flags_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic wr;
    logic [2:0] aff;
    // instruction write with no hardware event or bus write beside it
    assign wr = event_in == '0 && !avs_write && exec.valid && exec.write_dest;
    assign aff = {exec.affects_zero, exec.affects_nibble, exec.affects_carry};
    por_value_a: assert property ($rose(nrst) |-> flags_out == 8'h18)
        else $error("flags not at power-up value");
    reserved_zero_a: assert property (flags_out[6:5] == 2'b00)
        else $error("reserved bits not zero");
    arith_merge_a: assert property (wr && aff == 3'b111 && !exec.register_clear_op |=>
        flags_out[2:0] == $past({exec.zero, exec.nibble_carry, exec.carry}))
        else $error("arithmetic flags not from result");
    read_only_a: assert property (wr |=> $stable(flags_out[4:3]))
        else $error("read-only flags written");
    clear_pattern_a: assert property (wr && exec.register_clear_op |=>
        flags_out == (($past(flags_out) & 8'h1b) | 8'h04))
        else $error("clear pattern wrong");
    plain_write_a: assert property (wr && aff == 3'b000 && !exec.register_clear_op |=>
        {flags_out[7], flags_out[2:0]} == $past({exec.write_data[7], exec.write_data[2:0]}))
        else $error("plain write lost");
    sleep_flags_a: assert property ($onehot(event_in) && event_in.sleep_op |=>
        flags_out[4:3] == 2'b10)
        else $error("sleep flags wrong");
    expiry_flag_a: assert property ($onehot(event_in) && event_in.watchdog_timeout |=>
        !flags_out[4])
        else $error("expiry flag not cleared");
    bus_answer_a: assert property ($rose(avs_read || avs_write) |-> ##[1:4] !avs_waitrequest)
        else $error("bus answer late");
    cover property (wr && exec.register_clear_op);
    cover property (event_in.sleep_op);
    cover property (!avs_waitrequest && avs_write);
endmodule

bind core_status_flag_register core_status_flag_register_props u_props (.sys_clk(sys_clk),
    .nrst(nrst), .exec(exec), .event_in(event_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata), .flags_out(flags_out),
    .last_cause(last_cause));

// File: verification/exec_unit_model.sv
// behavioural execution unit issuing one instruction result at a time
module exec_unit_model (
    input wire logic sys_clk,
    output status_flags_pkg::exec_result_t exec
);
    import status_flags_pkg::*;
    initial exec = '0;
    task automatic issue(input logic [7:0] d, input logic [2:0] aff, input logic [2:0] res,
        input logic clr);
        @(posedge sys_clk);
        exec <= {2'b11, d & 8'h9f, aff, res, clr};
        @(posedge sys_clk);
        exec <= '0;
        #1;
    endtask
endmodule

// File: verification/core_status_flag_register_tb.sv
// self-checking bench for the core status flag register
module core_status_flag_register_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import status_flags_pkg::*;
    logic sys_clk, nrst, avs_read, avs_write, avs_waitrequest;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [7:0] flags_out;
    exec_result_t exec;
    reset_event_t event_in;
    reset_cause_t last_cause;
    int errors, cmp_count, cyc;
    core_status_flag_register dut (.sys_clk(sys_clk), .nrst(nrst), .exec(exec),
        .event_in(event_in), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .flags_out(flags_out), .last_cause(last_cause));
    exec_unit_model model (.sys_clk(sys_clk), .exec(exec));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one avalon transfer, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic pulse(input reset_event_t e);
        @(posedge sys_clk);
        event_in <= e;
        @(posedge sys_clk);
        event_in <= '0;
        #1;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        nrst = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        event_in = '0;
        repeat (6) @(posedge sys_clk);
        nrst <= 1'b1;
        bus(1'b0, 4'h0, 32'h0);
        chk("reset flags", rd, 32'h18);
        chk("reset cause", last_cause, cause_power_up);
        bus(1'b0, 4'h8, 32'h0);
        chk("unmapped", rd, 32'h0);
        model.issue(8'hff, 3'b000, 3'b000, 1'b0);
        chk("move", flags_out, 32'h9f);
        model.issue(8'h00, 3'b100, 3'b100, 1'b1);
        chk("clear", flags_out, 32'h1f);
        model.issue(8'he4, 3'b111, 3'b011, 1'b0);
        chk("add", flags_out, 32'h9b);
        bus(1'b1, 4'h0, 32'h60);
        bus(1'b0, 4'h0, 32'h0);
        chk("bus write", rd, 32'h18);
        pulse(6'h01);
        chk("sleep", flags_out, 32'h10);
        pulse(6'h02);
        chk("kick", flags_out, 32'h18);
        pulse(6'h04);
        chk("timeout", flags_out, 32'h08);
        chk("timeout cause", last_cause, cause_other);
        pulse(6'h10);
        chk("pin wake", flags_out[7], 32'h1);
        bus(1'b0, 4'h4, 32'h0);
        chk("record", rd, 32'h7);
        bus(1'b1, 4'h4, 32'h7);
        bus(1'b0, 4'h4, 32'h0);
        chk("record clear", rd, 32'h0);
        pulse(6'h08);
        chk("other reset", flags_out[7], 32'h0);
        pulse(6'h20);
        chk("power-up", flags_out[7:3], 32'h03);
        chk("power-up cause", last_cause, cause_power_up);
        summarize();
    end
endmodule
